// ===== logic/scm_pkg.sv
package scm_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int THRESH_NS = 120;
  localparam int THRESH_CYC = (THRESH_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS = 400;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_BIT_NS = 1000;
  localparam int HALF_CYC = HALF_BIT_NS / CLK_NS;
  localparam int PHASE1_US = 100000;
  localparam int PHASE1_CYC = PHASE1_US * 1000 / CLK_NS;
  // ---------------------------------------------------------------
  // Frames
  // ---------------------------------------------------------------
  localparam logic [15:0] ENTRY_KEY = 16'h5A5A;
  localparam logic [4:0] KEY_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h0E;
  localparam int FRAME_BITS = 18;
  localparam logic [1:0] START_BITS = 2'h1;
  localparam logic [2:0] SV_OK = 3'h5;
  localparam logic [2:0] SV_ERR = 3'h6;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_RW_POS = 12;
  localparam int CMD_PAR_POS = 13;
  localparam logic [3:0] EXIT_ADDR = 4'hA;
  localparam logic [7:0] EXIT_DATA = 8'h80;
  localparam logic [3:0] THIRD_CFG_ADDR = 4'h3;
  localparam int LOCK_BIT = 7;
  localparam int MON_EN_BIT = 0;
  localparam logic [7:0] RAM_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Register bus map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LASTCMD = 4'h8;
  localparam int CTRL_SYNC_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    SCM_PHASE1 = 3'b001,
    SCM_CFG = 3'b010,
    SCM_NORMAL = 3'b100
  } scm_state_t;

  // Reply word with even parity over all 16 bits
  function automatic logic [15:0] scm_reply(input logic [3:0] addr,
                                            input logic [7:0] data,
                                            input logic [2:0] sv);
    logic [14:0] body;
    body = {addr, data, sv};
    return {^body, body};
  endfunction
endpackage

// ===== logic/scm_tx_if.sv
`timescale 1ns/1ps
interface scm_tx_if;
  logic ce;
  logic start;
  logic abort;
  logic [15:0] word;
  logic busy;
  logic line;
  modport ctl (output ce, output start, output abort, output word,
               input busy, input line);
  modport tx (input ce, input start, input abort, input word,
              output busy, output line);
endinterface

// ===== logic/scm_manch_tx.sv
`timescale 1ns/1ps
module scm_manch_tx
  import scm_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  scm_tx_if.tx t
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [FRAME_BITS-1:0] sr_q;
  logic [4:0] left_q;
  logic half_q;
  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic line_q;

  // ---------------------------------------------------------------
  // Manchester-1 shifter, start bits then word LSB first
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q <= '0;
      left_q <= 5'h00;
      half_q <= 1'b0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      line_q <= 1'b0;
    end else if (t.ce) begin
      if (t.abort) begin
        busy_q <= 1'b0;
        line_q <= 1'b0;
      end else if (!busy_q) begin
        if (t.start) begin
          sr_q <= {t.word, START_BITS};
          left_q <= 5'(FRAME_BITS - 1);
          half_q <= 1'b0;
          cnt_q <= '0;
          busy_q <= 1'b1;
          line_q <= START_BITS[0];
        end
      end else if (cnt_q == CW'(HALF_CYCLES - 1)) begin
        cnt_q <= '0;
        if (!half_q) begin
          half_q <= 1'b1;
          line_q <= ~sr_q[0];
        end else if (left_q == 5'h00) begin
          busy_q <= 1'b0;
          line_q <= 1'b0;
        end else begin
          half_q <= 1'b0;
          sr_q <= sr_q >> 1;
          left_q <= left_q - 5'h01;
          line_q <= sr_q[1];
        end
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign t.busy = busy_q;
  assign t.line = line_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_tx_first_half: assert property (
    @(posedge clk) disable iff (!arst_n)
    t.ce && !t.abort && !busy_q && t.start |=> busy_q && line_q
  ) else $error("frame did not open with high half of start bit");
endmodule

// ===== logic/scm_link.sv
`timescale 1ns/1ps
module scm_link
  import scm_pkg::*;
#(
  parameter int PHASE1_CYCLES = PHASE1_CYC,
  parameter int HALF_CYCLES = HALF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic bus_supply_positive_pin,
  input wire logic power_fail_reset,
  output logic bus_current_hi_q,
  output logic analog_monitor_out_enable_q,
  output logic sync_pulse_q,
  output logic cfg_mode_q,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  scm_tx_if tx_bus ();

  logic [2:0] pin_sync_q;
  logic [2:0] pf_sync_q;
  logic lvl_q;
  logic pf_q;
  logic [7:0] hi_cnt_q;
  logic [7:0] lo_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] rx_sr_q;
  scm_state_t state_q;
  logic [31:0] p1_cnt_q;
  logic [7:0] ram_q [16];
  logic tx_start_q;
  logic [15:0] tx_word_q;
  logic [31:0] ctrl_q;
  logic [13:0] last_cmd_q;
  logic par_err_q;
  logic [31:0] readdata_q;
  logic wait_q;

  logic lvl_rise, lvl_fall, frame_end, key_hit, cmd_hit, par_ok, locked;
  logic is_write, is_exit, ram_we;
  logic [13:0] cmd;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;

  // ---------------------------------------------------------------
  // Pin synchronisers and pulse timing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_q <= 3'h0;
      pf_sync_q <= 3'h0;
      lvl_q <= 1'b0;
      pf_q <= 1'b0;
    end else if (clk_en) begin
      pin_sync_q <= {pin_sync_q[1:0], bus_supply_positive_pin};
      pf_sync_q <= {pf_sync_q[1:0], power_fail_reset};
      if (pin_sync_q[1] == pin_sync_q[2]) lvl_q <= pin_sync_q[2];
      if (pf_sync_q[1] == pf_sync_q[2]) pf_q <= pf_sync_q[2];
    end
  end

  assign lvl_rise = (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2]
                    && !lvl_q;
  assign lvl_fall = (pin_sync_q[1] == pin_sync_q[2]) && !pin_sync_q[2]
                    && lvl_q;
  assign frame_end = !lvl_q && lo_cnt_q == 8'(GAP_CYC - 1)
                     && bit_cnt_q != 5'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_q <= 8'h00;
      lo_cnt_q <= 8'h00;
      bit_cnt_q <= 5'h00;
      rx_sr_q <= 16'h0000;
    end else if (clk_en) begin
      if (pf_q) begin
        hi_cnt_q <= 8'h00;
        lo_cnt_q <= 8'h00;
        bit_cnt_q <= 5'h00;
      end else begin
        if (lvl_q && hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
        if (!lvl_q && lo_cnt_q != 8'hFF) lo_cnt_q <= lo_cnt_q + 8'h01;
        if (lvl_rise) lo_cnt_q <= 8'h00;
        if (lvl_fall) begin
          hi_cnt_q <= 8'h00;
          // Long pulse is a one
          rx_sr_q <= {hi_cnt_q >= 8'(THRESH_CYC), rx_sr_q[15:1]};
          if (bit_cnt_q != 5'h1F) bit_cnt_q <= bit_cnt_q + 5'h01;
        end else if (frame_end) begin
          bit_cnt_q <= 5'h00;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  assign key_hit = frame_end && bit_cnt_q == KEY_BITS
                   && rx_sr_q == ENTRY_KEY;
  assign cmd_hit = frame_end && bit_cnt_q == CMD_BITS;
  assign cmd = rx_sr_q[15:2];
  assign cmd_data = cmd[CMD_ADDR_LSB-1:CMD_DATA_LSB];
  assign cmd_addr = cmd[CMD_RW_POS-1:CMD_ADDR_LSB];
  assign par_ok = ~^cmd;
  assign locked = ram_q[THIRD_CFG_ADDR][LOCK_BIT];
  assign is_write = !cmd[CMD_RW_POS];
  assign is_exit = is_write && cmd_addr == EXIT_ADDR
                   && cmd_data == EXIT_DATA;
  assign ram_we = clk_en && !pf_q && state_q == SCM_CFG && cmd_hit
                  && par_ok && is_write && !is_exit && !locked;

  // ---------------------------------------------------------------
  // Mode sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SCM_PHASE1;
      p1_cnt_q <= 32'h0000_0000;
      cfg_mode_q <= 1'b0;
    end else if (clk_en) begin
      cfg_mode_q <= state_q == SCM_CFG;
      if (pf_q) begin
        state_q <= SCM_PHASE1;
        p1_cnt_q <= 32'h0000_0000;
      end else begin
        case (state_q)
          SCM_PHASE1: begin
            p1_cnt_q <= p1_cnt_q + 32'h0000_0001;
            if (key_hit) begin
              state_q <= SCM_CFG;
            end else if (p1_cnt_q == 32'(PHASE1_CYCLES - 1)) begin
              state_q <= SCM_NORMAL;
            end
          end
          SCM_CFG: begin
            if (cmd_hit && par_ok && is_exit) begin
              state_q <= SCM_PHASE1;
              p1_cnt_q <= 32'h0000_0000;
            end
          end
          SCM_NORMAL: state_q <= SCM_NORMAL;
          default: state_q <= SCM_PHASE1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Register RAM and replies
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) ram_q[i] <= RAM_RESET;
    end else if (ram_we) begin
      ram_q[cmd_addr] <= cmd_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_start_q <= 1'b0;
      tx_word_q <= 16'h0000;
      last_cmd_q <= 14'h0000;
      par_err_q <= 1'b0;
    end else if (clk_en) begin
      tx_start_q <= 1'b0;
      if (!pf_q) begin
        if (state_q == SCM_PHASE1 && key_hit) begin
          tx_start_q <= 1'b1;
          tx_word_q <= scm_reply(THIRD_CFG_ADDR, ram_q[THIRD_CFG_ADDR],
                                 SV_OK);
        end else if (state_q == SCM_CFG && cmd_hit) begin
          tx_start_q <= 1'b1;
          last_cmd_q <= cmd;
          par_err_q <= !par_ok;
          if (!par_ok) begin
            tx_word_q <= scm_reply(4'h0, 8'h00, SV_ERR);
          end else if (is_write && (is_exit || !locked)) begin
            tx_word_q <= scm_reply(cmd_addr, cmd_data, SV_OK);
          end else begin
            tx_word_q <= scm_reply(cmd_addr, ram_q[cmd_addr],
                                   SV_OK);
          end
        end
      end
    end
  end

  assign tx_bus.ce = clk_en;
  assign tx_bus.start = tx_start_q;
  assign tx_bus.abort = pf_q;
  assign tx_bus.word = tx_word_q;

  scm_manch_tx #(.HALF_CYCLES(HALF_CYCLES)) u_tx (
    .clk(clk),
    .arst_n(arst_n),
    .t(tx_bus.tx)
  );

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_current_hi_q <= 1'b0;
      analog_monitor_out_enable_q <= 1'b0;
      sync_pulse_q <= 1'b0;
    end else if (clk_en) begin
      bus_current_hi_q <= tx_bus.line && !pf_q;
      analog_monitor_out_enable_q <=
        ram_q[THIRD_CFG_ADDR][MON_EN_BIT];
      sync_pulse_q <= state_q == SCM_NORMAL && lvl_rise && !pf_q
                      && ctrl_q[CTRL_SYNC_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
        case (avs_address)
          REG_CTRL: readdata_q <= ctrl_q;
          REG_STATUS: readdata_q <= {26'h0, par_err_q, tx_bus.busy, pf_q,
                                     state_q};
          REG_LASTCMD: readdata_q <= {18'h0, last_cmd_q};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end else begin
        wait_q <= 1'b1;
        if (avs_write && !wait_q && avs_address == REG_CTRL) begin
          ctrl_q <= avs_writedata;
        end
      end
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = wait_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_pf_no_tx: assert property (pf_q && clk_en |=> !tx_start_q)
    else $error("reply started during power-fail reset");
  chk_pf_idle: assert property (pf_q && clk_en |=> !bus_current_hi_q)
    else $error("bus current not idle during power-fail reset");
  chk_mon_follow: assert property (clk_en |=>
    analog_monitor_out_enable_q == $past(ram_q[THIRD_CFG_ADDR][MON_EN_BIT]))
    else $error("monitor enable does not follow its bit");
  chk_cfg_entry: assert property (clk_en && state_q != SCM_CFG ##1
    state_q == SCM_CFG |-> $past(state_q) == SCM_PHASE1 && $past(key_hit))
    else $error("configuration mode entered outside phase one");
  chk_key_ack: assert property (clk_en && !pf_q && key_hit
    && state_q == SCM_PHASE1 |=> tx_start_q
    && tx_word_q[14:11] == THIRD_CFG_ADDR && tx_word_q[2:0] == SV_OK)
    else $error("key not answered with third config register");
  chk_len_filter: assert property (clk_en && frame_end
    && bit_cnt_q != CMD_BITS && state_q == SCM_CFG |=> !tx_start_q)
    else $error("frame of wrong length answered");
  chk_normal_quiet: assert property (state_q == SCM_NORMAL
    && $past(state_q) == SCM_NORMAL |-> !tx_start_q)
    else $error("reply sent outside configuration mode");
  chk_reply_parity: assert property (tx_start_q |-> ~^tx_word_q)
    else $error("reply parity not even");
  chk_parity_error: assert property (clk_en && !pf_q && cmd_hit
    && !par_ok && state_q == SCM_CFG
    |=> tx_start_q && tx_word_q == scm_reply(4'h0, 8'h00, SV_ERR))
    else $error("parity error reply malformed");
  chk_cfg_exit: assert property (clk_en && !pf_q && cmd_hit && par_ok
    && is_exit && state_q == SCM_CFG
    |=> state_q == SCM_PHASE1 && tx_start_q && p1_cnt_q == 32'h0)
    else $error("exit command not handled");
  chk_read_keeps: assert property (clk_en && cmd_hit && par_ok
    && !is_write |=> ram_q[$past(cmd_addr)] == $past(ram_q[cmd_addr]))
    else $error("read command altered a register");

  cov_key_entry: cover property (state_q == SCM_PHASE1 ##1
    state_q == SCM_CFG);
  cov_parity_err: cover property (tx_start_q && tx_word_q[2:0] == SV_ERR);
  cov_exit: cover property (state_q == SCM_CFG ##1 state_q == SCM_PHASE1);
endmodule

// ===== verification/scm_ctl_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Controller side of the two-wire bus
// ---------------------------------------------------------------
module scm_ctl_model #(
  parameter int HALF_CYCLES = 8
) (
  input wire logic clk,
  input wire logic bus_current_hi_q,
  output logic bus_supply_positive_pin
);
  initial bus_supply_positive_pin = 1'b0;

  // Long pulse 1, short pulse 0, LSB first, line low after
  task automatic send_frame(input logic [15:0] bits, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bus_supply_positive_pin <= 1'b1;
      repeat (bits[i] ? 20 : 6) @(posedge clk);
      bus_supply_positive_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask

  // Manchester-1 capture, first bit sent lands in f[0]
  task automatic get_reply(output logic [17:0] f, output bit got,
                           output bit mok);
    int n;
    logic h;
    n = 0;
    got = 0;
    mok = 1;
    f = '0;
    do begin
      @(negedge clk);
      n++;
    end while (bus_current_hi_q !== 1'b1 && n < 200);
    if (bus_current_hi_q !== 1'b1) return;
    got = 1;
    repeat (HALF_CYCLES / 2 - 1) @(negedge clk);
    for (int i = 0; i < 18; i++) begin
      h = bus_current_hi_q;
      repeat (HALF_CYCLES) @(negedge clk);
      if (bus_current_hi_q !== ~h) mok = 0;
      f[i] = h;
      repeat (HALF_CYCLES) @(negedge clk);
    end
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import scm_pkg::*;
  localparam int P1 = 4000;
  localparam int HC = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pin;
  logic pf = 1'b0;
  logic cur;
  logic mon;
  logic sync_p;
  logic cfg;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int n_sync = 0;

  always #4 clk = ~clk;
  always @(posedge clk) if (sync_p === 1'b1) n_sync++;

  scm_link #(.PHASE1_CYCLES(P1), .HALF_CYCLES(HC)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1),
    .bus_supply_positive_pin(pin), .power_fail_reset(pf),
    .bus_current_hi_q(cur), .analog_monitor_out_enable_q(mon),
    .sync_pulse_q(sync_p), .cfg_mode_q(cfg),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  scm_ctl_model #(.HALF_CYCLES(HC)) ctl (
    .clk(clk), .bus_current_hi_q(cur), .bus_supply_positive_pin(pin)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t %s: got %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic av_cycle(input logic wr, input logic [3:0] a,
                          input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Even parity over 14 bits, data low, parity last
  function automatic logic [15:0] cmd(input logic rw, input logic [3:0] a,
                                      input logic [7:0] d);
    cmd = {2'b00, ^{rw, a, d}, rw, a, d};
  endfunction

  function automatic logic [15:0] word(input logic [3:0] a,
                                       input logic [7:0] d,
                                       input logic [2:0] sv);
    word = {^{a, d, sv}, a, d, sv};
  endfunction

  task automatic xact(input logic [15:0] bits, input int n,
                      input bit exp_got, input logic [15:0] exp_w);
    logic [17:0] f;
    bit got;
    bit mok;
    ctl.send_frame(bits, n);
    ctl.get_reply(f, got, mok);
    check(32'(got), 32'(exp_got), "reply present");
    if (got && exp_got) begin
      check(32'({f[0], f[1]}), 32'h2, "start bits");
      check(32'(mok), 32'h1, "manchester");
      check(32'(f[17:2]), 32'(exp_w), "word");
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    av_cycle(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, CTRL_RESET, "ctrl reset");
    av_cycle(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
    av_cycle(1'b0, 4'hC, 32'h0, rd);
    check(rd, 32'h0, "unmapped");
    check(32'(mon), 32'h0, "monitor default");
    check(32'({cfg, cur}), 32'h0, "idle outputs");
  endtask

  task automatic t_bad_key();
    xact(16'h5A5B, 16, 0, 16'h0);
    xact(cmd(1'b1, 4'h3, 8'h00), 14, 0, 16'h0);
    check(32'(cfg), 32'h0, "no entry");
  endtask

  task automatic t_enter(input logic [7:0] r3);
    xact(ENTRY_KEY, 16, 1,
         word(THIRD_CFG_ADDR, r3, SV_OK));
    repeat (4) @(posedge clk);
    check(32'(cfg), 32'h1, "cfg mode");
  endtask

  task automatic t_rw();
    xact(cmd(1'b0, 4'h2, 8'hAA), 14, 1, word(4'h2, 8'hAA, SV_OK));
    xact(cmd(1'b1, 4'h2, 8'h55), 14, 1, word(4'h2, 8'hAA, SV_OK));
    xact(ENTRY_KEY, 16, 0, 16'h0);
    av_cycle(1'b0, REG_LASTCMD, 32'h0, rd);
    check(rd & 32'h3FFF, 32'(cmd(1'b1, 4'h2, 8'h55)), "last cmd");
    xact(cmd(1'b0, 4'h3, 8'h01), 14, 1, word(4'h3, 8'h01, SV_OK));
    check(32'(mon), 32'h1, "monitor on");
    xact(cmd(1'b0, 4'h3, 8'h00), 14, 1, word(4'h3, 8'h00, SV_OK));
    check(32'(mon), 32'h0, "monitor off");
  endtask

  task automatic t_parity();
    xact(cmd(1'b0, 4'h2, 8'hAA) ^ 16'h1, 14, 1, word(4'h0, 8'h0, SV_ERR));
    av_cycle(1'b0, REG_STATUS, 32'h0, rd);
    check(rd & 32'h22, 32'h22, "status error");
    xact(cmd(1'b1, 4'h2, 8'h00), 14, 1, word(4'h2, 8'hAA, SV_OK));
  endtask

  task automatic t_exit();
    // Lock bit set, later writes other than the exit command return the stored value
    xact(cmd(1'b0, THIRD_CFG_ADDR, 8'h80), 14, 1,
         word(THIRD_CFG_ADDR, 8'h80, SV_OK));
    xact(cmd(1'b0, 4'h2, 8'h11), 14, 1,
         word(4'h2, 8'hAA, SV_OK));
    xact(cmd(1'b0, EXIT_ADDR, EXIT_DATA), 14, 1,
         word(EXIT_ADDR, EXIT_DATA, SV_OK));
    repeat (4) @(posedge clk);
    check(32'(cfg), 32'h0, "exit");
    t_enter(8'h80);
  endtask

  task automatic t_power_fail();
    int hi;
    hi = 0;
    ctl.send_frame(cmd(1'b1, 4'h2, 8'h00), 14);
    @(posedge cur);
    @(posedge clk);
    pf <= 1'b1;
    repeat (8) @(posedge clk);
    repeat (400) begin
      @(negedge clk);
      if (cur !== 1'b0) hi++;
    end
    check(32'(hi), 32'h0, "quiet in reset");
    xact(ENTRY_KEY, 16, 0, 16'h0);
    check(32'(cfg), 32'h0, "reset leaves cfg");
    @(posedge clk);
    pf <= 1'b0;
  endtask

  task automatic t_after_phase1();
    int s0;
    av_cycle(1'b1, REG_CTRL, 32'h1, rd);
    repeat (P1 + 200) @(posedge clk);
    s0 = n_sync;
    xact(ENTRY_KEY, 16, 0, 16'h0);
    check(32'(n_sync - s0), 32'd16, "sync pulses");
    check(32'(cfg), 32'h0, "late key");
    av_cycle(1'b1, REG_CTRL, 32'h0, rd);
    s0 = n_sync;
    xact(16'h00FF, 16, 0, 16'h0);
    check(32'(n_sync - s0), 32'd0, "async ignores");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_bad_key();
    t_enter(RAM_RESET);
    t_rw();
    t_parity();
    t_exit();
    t_power_fail();
    t_after_phase1();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end
endmodule
